// ==== fbp_pkg.sv ====
// Package for the flash block protection gate.
// Assumes one system clock domain; the word-indexed flash array is held inside the gate.
package fbp_pkg;
  // ==========================================================================
  // Geometry.
  localparam int FLASH_BYTES = 65536;
  localparam int ERASE_BYTES = 1024;
  localparam int PROT_BYTES = 2048;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int NUM_REGIONS = FLASH_BYTES / PROT_BYTES;
  localparam int REGION_LSB = 11;
  localparam int BLOCK_LSB = 10;
  localparam int WORDS_PER_BLOCK = ERASE_BYTES / 4;
  // ==========================================================================
  // Protection codes and erased value.
  localparam logic [1:0] PROT_OPEN = 2'h0;
  localparam logic [1:0] PROT_RDONLY = 2'h1;
  localparam logic [1:0] PROT_XONLY = 2'h2;
  localparam logic [DATA_W-1:0] ERASED_WORD = 32'hffff_ffff;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  // ==========================================================================
  // Request kinds.
  typedef enum logic [2:0] {
    FBP_FETCH = 3'h0,
    FBP_DREAD = 3'h1,
    FBP_DBG_READ = 3'h2,
    FBP_PROG = 3'h3,
    FBP_ERASE = 3'h4
  } fbp_op_t;

  typedef struct packed {
    fbp_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fbp_req_t;
endpackage

// ==== fbp_gate.sv ====
// Flash block protection gate with its 64 KB array.
// Assumes requests come from logic on i_clk, one at a time while idle.
// Overview of operation
// R1: The gate holds a 64 KB flash array that it reads, erases and programs.
// R2: Each 1 KB block can be erased alone without touching any other block.
// R3: A completed erase leaves every bit of the block set to one.
// R4: Protection applies to 2 KB regions, each two adjacent erase blocks.
// R5: Each region is open, read-only or execute-only.
// R6: Erase or program aimed at a read-only region is refused.
// R7: Execute-only regions refuse writes and allow only instruction fetches.
// R8: Execute-only regions block data reads and debugger reads.
// R9: A refused request raises a sticky violation flag and returns no data.
`timescale 1ns/100ps
module fbp_gate
  import fbp_pkg::*;
#(
  parameter int NREG = NUM_REGIONS
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_req_valid,
  input wire fbp_pkg::fbp_req_t i_req,
  input wire logic [2*NREG-1:0] i_prot,
  input wire logic i_viol_clr,
  output logic o_busy,
  output logic o_done,
  output logic o_refused,
  output logic [fbp_pkg::DATA_W-1:0] o_rdata,
  output logic o_viol
);
  import fbp_pkg::*;

  // ==========================================================================
  // Storage and state.
  localparam int NWORDS = FLASH_BYTES / 4;
  localparam logic [7:0] LAST_WORD = 8'(WORDS_PER_BLOCK - 1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ERASE = 3'b010,
    ST_DONE = 3'b100
  } fbp_state_t;

  logic [DATA_W-1:0] mem [NWORDS]; // R1
  fbp_state_t state_ff;
  logic [5:0] blk_ff;
  logic [7:0] wcnt_ff;
  logic [1:0] prot_sel;
  logic allow;
  logic is_write;
  logic take;

  // Protection of the addressed 2 KB region.
  assign prot_sel = i_prot[2*i_req.addr[ADDR_W-1:REGION_LSB] +: 2]; // R4 R5
  assign is_write = (i_req.op == FBP_PROG) || (i_req.op == FBP_ERASE);
  assign take = i_req_valid && (state_ff == ST_IDLE);

  // Decide whether the request passes the region's setting.
  always_comb begin
    case (prot_sel)
      PROT_RDONLY: allow = !is_write; // R6
      PROT_XONLY: allow = (i_req.op == FBP_FETCH); // R7 R8
      default: allow = 1'b1;
    endcase
  end

  // Sequencer: reads and programs take one cycle, erase walks the block.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff <= ST_IDLE;
      blk_ff <= 6'h00;
      wcnt_ff <= 8'h00;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (take && allow && i_req.op == FBP_ERASE) begin
            state_ff <= ST_ERASE;
            blk_ff <= i_req.addr[ADDR_W-1:BLOCK_LSB]; // R2
            wcnt_ff <= 8'h00;
          end
        end
        ST_ERASE: begin
          wcnt_ff <= wcnt_ff + 8'h01;
          if (wcnt_ff == LAST_WORD) begin
            state_ff <= ST_DONE;
          end
        end
        ST_DONE: state_ff <= ST_IDLE;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Array writes: program clears bits, erase sets words to all ones.
  always_ff @(posedge i_clk) begin
    if (state_ff == ST_ERASE) begin
      mem[{blk_ff, wcnt_ff}] <= ERASED_WORD; // R2 R3
    end else if (take && allow && i_req.op == FBP_PROG) begin
      mem[i_req.addr[ADDR_W-1:2]] <= mem[i_req.addr[ADDR_W-1:2]] &
                                     i_req.wdata; // R6
    end
  end

  // Answer outputs, one-cycle done pulse and read data.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_done <= 1'b0;
      o_refused <= 1'b0;
      o_rdata <= ZERO_WORD;
      o_busy <= 1'b0;
    end else begin
      o_done <= 1'b0;
      o_refused <= 1'b0;
      o_busy <= (state_ff == ST_ERASE && wcnt_ff != LAST_WORD) ||
                (take && allow && i_req.op == FBP_ERASE);
      if (state_ff == ST_DONE) begin
        o_done <= 1'b1;
      end else if (take) begin
        if (!allow) begin
          o_done <= 1'b1;
          o_refused <= 1'b1;
          o_rdata <= ZERO_WORD; // R9
        end else if (i_req.op != FBP_ERASE) begin
          o_done <= 1'b1;
          o_rdata <= is_write ? ZERO_WORD : mem[i_req.addr[ADDR_W-1:2]];
        end
      end
    end
  end

  // Sticky violation flag; a new refusal wins over a clear.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_viol <= 1'b0;
    end else if (take && !allow) begin
      o_viol <= 1'b1; // R9
    end else if (i_viol_clr) begin
      o_viol <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks.
  property p_xonly_dread;
    @(posedge i_clk) disable iff (!i_arst_n)
    take && prot_sel == PROT_XONLY && i_req.op != FBP_FETCH
      |=> o_refused && o_rdata == ZERO_WORD;
  endproperty
  a_xonly_dread: assert property (p_xonly_dread) // R8
    else $error("Execute-only region leaked a non-fetch read.");

  property p_rdonly_write;
    @(posedge i_clk) disable iff (!i_arst_n)
    take && prot_sel == PROT_RDONLY && is_write |=> o_refused;
  endproperty
  a_rdonly_write: assert property (p_rdonly_write) // R6
    else $error("Write to read-only region was not refused.");

  property p_xonly_write;
    @(posedge i_clk) disable iff (!i_arst_n)
    take && prot_sel == PROT_XONLY && is_write |=> o_refused;
  endproperty
  a_xonly_write: assert property (p_xonly_write) // R7
    else $error("Write to execute-only region was not refused.");

  property p_fetch_ok;
    @(posedge i_clk) disable iff (!i_arst_n)
    take && i_req.op == FBP_FETCH |=> o_done && !o_refused;
  endproperty
  a_fetch_ok: assert property (p_fetch_ok) // R5
    else $error("Instruction fetch was refused.");

  property p_viol_set;
    @(posedge i_clk) disable iff (!i_arst_n)
    take && !allow |=> o_viol;
  endproperty
  a_viol_set: assert property (p_viol_set) // R9
    else $error("Violation flag missed a refusal.");

  property p_erase_len;
    @(posedge i_clk) disable iff (!i_arst_n)
    take && allow && i_req.op == FBP_ERASE |-> ##258 o_done;
  endproperty
  a_erase_len: assert property (p_erase_len) // R2
    else $error("Erase did not finish after 256 word writes.");

  property p_erase_ones;
    @(posedge i_clk) disable iff (!i_arst_n)
    state_ff == ST_ERASE |=> mem[$past({blk_ff, wcnt_ff})] == ERASED_WORD;
  endproperty
  a_erase_ones: assert property (p_erase_ones) // R3
    else $error("Erased word is not all ones.");

  property p_open_read;
    @(posedge i_clk) disable iff (!i_arst_n)
    take && prot_sel == PROT_OPEN && !is_write |=> o_done && !o_refused;
  endproperty
  a_open_read: assert property (p_open_read) // R1
    else $error("Read of open region was refused.");

  property p_refused_done;
    @(posedge i_clk) disable iff (!i_arst_n)
    o_refused |-> o_done;
  endproperty
  a_refused_done: assert property (p_refused_done) // R9
    else $error("Refusal shown without an answer.");

  property p_viol_hold;
    @(posedge i_clk) disable iff (!i_arst_n)
    o_viol && !i_viol_clr |=> o_viol;
  endproperty
  a_viol_hold: assert property (p_viol_hold) // R9
    else $error("Violation flag dropped without a clear.");

  property p_busy_erase;
    @(posedge i_clk) disable iff (!i_arst_n)
    state_ff == ST_ERASE |-> o_busy;
  endproperty
  a_busy_erase: assert property (p_busy_erase) // R2
    else $error("Busy low while a block erase runs.");

  property p_refused_idle;
    @(posedge i_clk) disable iff (!i_arst_n)
    take && !allow |=> !o_busy && state_ff == ST_IDLE;
  endproperty
  a_refused_idle: assert property (p_refused_idle) // R6
    else $error("Refused request started the erase walk.");
endmodule

// ==== fbp_host.sv ====
// Requester model: instruction fetch, data bus and debugger.
// Assumes the gate answers each request with a done pulse.
`timescale 1ns/100ps
module fbp_host
  import fbp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_done,
  output logic o_valid,
  output fbp_pkg::fbp_req_t o_req
);
  // =======
  // Idle request lines at time zero.
  initial begin
    o_valid = 1'h0;
    o_req = '0;
  end
  // Holds one request over its taking edge, then waits for the answer.
  task automatic xfer(input fbp_op_t op, input logic [15:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk) #1;
    o_valid = 1'h1;
    o_req = '{op, a, d};
    @(posedge i_clk) #1;
    o_valid = 1'h0;
    o_req = fbp_req_t'(~o_req); // Released lines lose the last value.
    while (o_valid !== 1'h1 && i_done !== 1'h1 && n < 300) begin
      @(posedge i_clk) #1;
      n++;
    end
  endtask
endmodule

// ==== tb_top.sv ====
// Testbench: random and corner requests against the protection gate.
// Assumes fbp_host as requester; assertions sit in the design.
`timescale 1ns/100ps
module tb_top;
  import fbp_pkg::*;
  logic i_clk, i_arst_n, i_viol_clr, i_req_valid;
  logic o_busy, o_done, o_refused, o_viol;
  fbp_req_t i_req;
  logic [63:0] i_prot;
  logic [31:0] o_rdata;
  logic [31:0] mem [16384];
  logic [15:0] at [3] = '{16'h1800, 16'h1ffc, 16'h2000};
  int n_fail, comparisons, cyc, busy_n;
  fbp_gate i_fbp_gate (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_req_valid(i_req_valid), .i_req(i_req), .i_prot(i_prot),
    .i_viol_clr(i_viol_clr), .o_busy(o_busy), .o_done(o_done),
    .o_refused(o_refused), .o_rdata(o_rdata), .o_viol(o_viol));
  fbp_host i_fbp_host (.i_clk(i_clk), .i_done(o_done),
    .o_valid(i_req_valid), .o_req(i_req));
  // =======
  // Clock, and a cycle ceiling that cuts a hang short.
  initial begin
    i_clk = 1'h0;
    forever #20 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (o_busy === 1'h1) busy_n++; // Edges seen with busy high.
    if (cyc == 60000) begin
      n_fail++;
      summarize();
    end
  end
  // =======
  // Comparisons and the verdict.
  task automatic chk_d(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %0t data %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %0t flag %b exp %b", $time, g, e);
    end
  endtask
  task automatic chk_n(input int g, input int e);
    comparisons++;
    if (g != e) begin
      n_fail++;
      $display("MISMATCH %0t count %0d exp %0d", $time, g, e);
    end
  endtask
  task automatic summarize();
    if (n_fail == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Whether a region setting refuses a request kind.
  function automatic logic no_go(input logic [1:0] p, input fbp_op_t op);
    return (p == PROT_RDONLY && (op == FBP_PROG || op == FBP_ERASE)) ||
           (p == PROT_XONLY && op != FBP_FETCH);
  endfunction
  // One request, its checks and the shadow array update.
  task automatic run(input fbp_op_t op, input logic [15:0] a,
                     input logic [31:0] d);
    logic r;
    r = no_go(i_prot[2*a[15:11] +: 2], op);
    busy_n = 0;
    i_fbp_host.xfer(op, a, d);
    chk_b(o_done, 1'h1);
    chk_b(o_refused, r);
    if (op < FBP_PROG) chk_d(o_rdata, r ? ZERO_WORD : mem[a[15:2]]);
    if (op == FBP_PROG) chk_d(o_rdata, ZERO_WORD);
    chk_n(busy_n, (!r && op == FBP_ERASE) ? WORDS_PER_BLOCK : 0);
    if (r) chk_b(o_viol, 1'h1);
    if (!r && op == FBP_PROG) mem[a[15:2]] &= d;
    if (!r && op == FBP_ERASE) for (int i = 0; i < 256; i++)
      mem[{a[15:10], i[7:0]}] = ERASED_WORD;
  endtask
  // =======
  // Main sequence: fill, corners, every setting, then random traffic.
  initial begin
    i_arst_n = 1'h0;
    i_viol_clr = 1'h0;
    i_prot = '0;
    void'($urandom(74979));
    repeat (2) @(posedge i_clk);
    #1 i_arst_n = 1'h1;
    chk_b(o_busy, 1'h0);
    chk_b(o_viol, 1'h0);
    chk_d(o_rdata, ZERO_WORD);
    for (int b = 0; b < 64; b++) run(FBP_ERASE, 16'(b * 1024), '0);
    run(FBP_DREAD, 16'hfffc, '0);
    run(FBP_PROG, 16'h1404, 32'h5a5a_0ff0);
    run(FBP_ERASE, 16'h1000, '0);
    run(FBP_DBG_READ, 16'h1404, '0);
    for (int p = 0; p < 4; p++) begin
      i_prot = 64'(p) << 6;
      for (int k = 0; k < 15; k++)
        run(fbp_op_t'(k % 5), at[k / 5], $urandom);
    end
    @(posedge i_clk) #1 i_viol_clr = 1'h1;
    @(posedge i_clk) #1 i_viol_clr = 1'h0;
    chk_b(o_viol, 1'h0);
    repeat (300) begin
      i_prot = {$urandom, $urandom};
      run(fbp_op_t'($urandom_range(4)), 16'($urandom), $urandom);
    end
    summarize();
  end
endmodule
